// *** hw/pdmux_params.svh ***
// Constants for the upper port D pin function multiplexer.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PDMUX_PARAMS_SVH
`define PDMUX_PARAMS_SVH
`define PDM_NUM_PINS 9
`define PDM_FIELD_W 2
`define PDM_CTRL_W 16
`define PDM_CTRL_RESET 16'h0000
`define PDM_ADR_BITS 8
`define PDM_OFS_CTRL1 8'h00
`define PDM_OFS_CTRL2 8'h04
`define PDM_OFS_STATUS 8'h08
`define PDM_CODE_GPIO 2'h0
`define PDM_CODE_DATA 2'h1
`define PDM_CODE_ALT 2'h2
`define PDM_CODE_RSVD 2'h3
`define PDM_R1_FIRST_PIN 3
`define PDM_R2_FIRST_LSB 10
`define PDM_FIRST_OUT_ALT 5
`define PDM_SINGLE_ALT_PINS 3
`define PDM_ALT_IDLE 1'b1
`endif

// *** hw/pdmux_pkg.sv ***
// Types shared by the upper port D pin function multiplexer.
// Assumes nothing of its surroundings.
package pdmux_pkg;
   typedef enum logic [1:0] {FUNC_GPIO, FUNC_DATA, FUNC_ALT} func_e;
   typedef logic [15:0] ctrl_t;
endpackage

// *** hw/pdmux_pin_cell.sv ***
// One multiplexed pin: picks its function and registers the pin drive.
// Assumes pin and peripheral inputs synchronous to clk_i.
`include "pdmux_params.svh"
module pdmux_pin_cell #(
   parameter bit ALT_IS_OUT = 1'b0,
   parameter bit ALT_SINGLE_OK = 1'b0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Selection
   input wire logic [1:0] mode_i,
   input wire logic single_chip_i,
   input wire logic rom_less_32_i,
   // Function sources
   input wire logic gpio_out_i,
   input wire logic gpio_oe_i,
   input wire logic data_out_i,
   input wire logic data_oe_i,
   input wire logic alt_out_i,
   input wire logic pin_i,
   // Results
   output pdmux_pkg::func_e func_o,
   output logic pin_o,
   output logic pin_oe_o,
   output logic gpio_in_o,
   output logic data_in_o,
   output logic alt_in_o
);
   import pdmux_pkg::*;
   logic pin_next, oe_next, gin_next, din_next, ain_next;

   always_comb begin
      if (rom_less_32_i) begin
         func_o = FUNC_DATA;
      end else begin
         case (mode_i)
            `PDM_CODE_DATA: func_o = single_chip_i ? FUNC_GPIO : FUNC_DATA;
            `PDM_CODE_ALT: begin
               func_o = (single_chip_i && !ALT_SINGLE_OK) ? FUNC_GPIO
                                                          : FUNC_ALT;
            end
            default: func_o = FUNC_GPIO;
         endcase
      end
   end

   // Inputs of unselected alternate functions rest at their idle level.
   always_comb begin
      pin_next = gpio_out_i;
      oe_next = gpio_oe_i;
      din_next = 1'b0;
      ain_next = `PDM_ALT_IDLE;
      gin_next = pin_i;
      case (func_o)
         FUNC_DATA: begin
            pin_next = data_out_i;
            oe_next = data_oe_i;
            din_next = pin_i;
         end
         FUNC_ALT: begin
            pin_next = ALT_IS_OUT ? alt_out_i : 1'b0;
            oe_next = ALT_IS_OUT;
            ain_next = ALT_IS_OUT ? `PDM_ALT_IDLE : pin_i;
         end
         default: begin
            pin_next = gpio_out_i;
            oe_next = gpio_oe_i;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o <= 1'b0;
         pin_oe_o <= 1'b0;
         gpio_in_o <= 1'b0;
         data_in_o <= 1'b0;
         alt_in_o <= `PDM_ALT_IDLE;
      end else begin
         pin_o <= pin_next;
         pin_oe_o <= oe_next;
         gpio_in_o <= gin_next;
         data_in_o <= din_next;
         alt_in_o <= ain_next;
      end
   end
endmodule

// *** hw/pdmux_wb_regs.sv ***
// Classic Wishbone slave holding the two function select registers.
// Assumes a master that holds its request until it samples ack.
`include "pdmux_params.svh"
module pdmux_wb_regs #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Block side
   input wire logic [17:0] stat_i,
   output pdmux_pkg::ctrl_t ctrl1_o,
   output pdmux_pkg::ctrl_t ctrl2_o
);
   import pdmux_pkg::*;
   logic acc, commit, ack_next;
   logic [31:0] dat_next;
   ctrl_t ctrl1_next, ctrl2_next;

   function automatic logic hit(input logic [ADDR_W-1:0] adr,
                                input logic [7:0] ofs);
      hit = (adr == ADDR_W'(ofs));
   endfunction

   function automatic ctrl_t merge(input ctrl_t old,
                                   input logic [31:0] dat,
                                   input logic [3:0] sel);
      merge = old;
      if (sel[0]) merge[7:0] = dat[7:0];
      if (sel[1]) merge[15:8] = dat[15:8];
   endfunction

   // Writes commit on the edge where the master samples ack.
   always_comb begin
      acc = wb_cyc_i && wb_stb_i;
      commit = acc && wb_we_i && wb_ack_o;
      ack_next = acc && !wb_ack_o;
      ctrl1_next = ctrl1_o;
      ctrl2_next = ctrl2_o;
      dat_next = wb_dat_o;
      if (commit && hit(wb_adr_i, `PDM_OFS_CTRL1)) begin
         ctrl1_next = merge(ctrl1_o, wb_dat_i, wb_sel_i);
      end
      if (commit && hit(wb_adr_i, `PDM_OFS_CTRL2)) begin
         ctrl2_next = merge(ctrl2_o, wb_dat_i, wb_sel_i);
      end
      if (ack_next) begin
         dat_next = 32'h0000_0000;
         if (hit(wb_adr_i, `PDM_OFS_CTRL1)) dat_next[15:0] = ctrl1_o;
         if (hit(wb_adr_i, `PDM_OFS_CTRL2)) dat_next[15:0] = ctrl2_o;
         if (hit(wb_adr_i, `PDM_OFS_STATUS)) dat_next[17:0] = stat_i;
      end
   end

   // Only power-on reset reaches rst_i, so other resets keep settings.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl1_o <= `PDM_CTRL_RESET;
         ctrl2_o <= `PDM_CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ctrl1_o <= ctrl1_next;
         ctrl2_o <= ctrl2_next;
         wb_ack_o <= ack_next;
         wb_dat_o <= dat_next;
      end
   end
endmodule

// *** hw/port_d_upper_pin_function_mux.sv ***
// Pin function multiplexer for upper port D bits 29 down to 21.
// Assumes rst_i is the power-on reset and all inputs are synchronous.
//
// Operation
// - Control register 2 is a 16-bit read/write register whose three 2-bit fields sit in bits 15:10, cleared to zero.
// - Bit 29 codes: 00 general I/O, 01 data line 29, 10 area 3 chip select, 11 reserved.
// - Register 1 bits 9:8 select bit 28: I/O, data line 28 or area 2 chip select.
// - Register 1 bits 7:6 select bit 27: I/O, data line 27 or DMA channel 1 acknowledge.
// - Register 1 bits 5:4 select bit 26: I/O, data line 26 or DMA channel 0 acknowledge.
// - Register 1 bits 3:2 select bit 25: I/O, data line 25 or DMA channel 1 request.
// - Register 1 bits 1:0 select bit 24: I/O, data line 24 or DMA channel 0 request.
// - Register 2 bits 15:14 select bit 23: I/O, data line 23 or interrupt input 7.
// - Register 2 bits 13:12 select bit 22: I/O, data line 22 or interrupt input 6.
// - Register 2 bits 11:10 select bit 21, whose alternate is interrupt input 5.
// - In single-chip mode bits 29 to 24 fall back to general I/O for data or alternate codes.
// - With no ROM and a 32-bit area 0 every pin is its data line whatever the field.
// - Both registers clear only on power-on reset and keep their value otherwise.
`include "pdmux_params.svh"
module port_d_upper_pin_function_mux #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Operating mode
   input wire logic single_chip_i,
   input wire logic rom_less_32_i,
   // General I/O, bit 0 is port bit 21
   input wire logic [8:0] gpio_out_i,
   input wire logic [8:0] gpio_oe_i,
   output logic [8:0] gpio_in_o,
   // External data bus lines 29 down to 21
   input wire logic [8:0] data_out_i,
   input wire logic [8:0] data_oe_i,
   output logic [8:0] data_in_o,
   // Alternate outputs
   input wire logic area3_chip_select_i,
   input wire logic area2_chip_select_i,
   input wire logic dma_ch1_acknowledge_i,
   input wire logic dma_ch0_acknowledge_i,
   // Alternate inputs
   output logic dma_ch1_request_o,
   output logic dma_ch0_request_o,
   output logic ext_interrupt_7_o,
   output logic ext_interrupt_6_o,
   output logic ext_interrupt_5_o,
   // Pins
   input wire logic [8:0] portd_pin_i,
   output logic [8:0] portd_pin_o,
   output logic [8:0] portd_pin_oe_o
);
   import pdmux_pkg::*;

   localparam int NUM_PINS = `PDM_NUM_PINS;

   ctrl_t ctrl1, ctrl2;
   logic [1:0] mode [NUM_PINS];
   func_e func [NUM_PINS];
   logic [NUM_PINS-1:0] func_gpio;
   logic [NUM_PINS-1:0] alt_out, alt_in;
   logic [17:0] stat;
   logic plain;

   if (ADDR_W < `PDM_ADR_BITS) begin : g_chk
      $error("ADDR_W too small for the register map");
   end

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   pdmux_wb_regs #(.ADDR_W(ADDR_W)) u_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .stat_i(stat),
      .ctrl1_o(ctrl1),
      .ctrl2_o(ctrl2)
   );

   // ----------------------------------------------------------------
   // Pin cells
   // ----------------------------------------------------------------
   // Chip selects and acknowledges are outputs; requests and interrupts
   // are inputs, and only the interrupts survive single-chip mode.
   assign alt_out = {area3_chip_select_i, area2_chip_select_i,
                     dma_ch1_acknowledge_i,
                     dma_ch0_acknowledge_i, 5'h00};
   assign dma_ch1_request_o = alt_in[4];
   assign dma_ch0_request_o = alt_in[3];
   assign ext_interrupt_7_o = alt_in[2];
   assign ext_interrupt_6_o = alt_in[1];
   assign ext_interrupt_5_o = alt_in[0];

   for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
      if (k >= `PDM_R1_FIRST_PIN) begin : g_r1
         assign mode[k] = ctrl1[(k - `PDM_R1_FIRST_PIN) * `PDM_FIELD_W
                                +: `PDM_FIELD_W];
      end else begin : g_r2
         assign mode[k] = ctrl2[`PDM_R2_FIRST_LSB + k * `PDM_FIELD_W
                                +: `PDM_FIELD_W];
      end
      pdmux_pin_cell #(
         .ALT_IS_OUT(k >= `PDM_FIRST_OUT_ALT),
         .ALT_SINGLE_OK(k < `PDM_SINGLE_ALT_PINS)
      ) u_cell (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .mode_i(mode[k]),
         .single_chip_i(single_chip_i),
         .rom_less_32_i(rom_less_32_i),
         .gpio_out_i(gpio_out_i[k]),
         .gpio_oe_i(gpio_oe_i[k]),
         .data_out_i(data_out_i[k]),
         .data_oe_i(data_oe_i[k]),
         .alt_out_i(alt_out[k]),
         .pin_i(portd_pin_i[k]),
         .func_o(func[k]),
         .pin_o(portd_pin_o[k]),
         .pin_oe_o(portd_pin_oe_o[k]),
         .gpio_in_o(gpio_in_o[k]),
         .data_in_o(data_in_o[k]),
         .alt_in_o(alt_in[k])
      );
      assign stat[k * `PDM_FIELD_W +: `PDM_FIELD_W] = 2'(func[k]);
      assign func_gpio[k] = (func[k] == FUNC_GPIO);
   end

   assign plain = !single_chip_i && !rom_less_32_i;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_regs_reset_zero: assert property ($fell(rst_i) |->
      ctrl1 == `PDM_CTRL_RESET && ctrl2 == `PDM_CTRL_RESET)
      else $error("control registers not clear after reset");
   a_ctrl2_write: assert property (wb_cyc_i && wb_stb_i && wb_we_i
      && wb_ack_o && wb_adr_i == ADDR_W'(`PDM_OFS_CTRL2)
      && wb_sel_i[1:0] == 2'h3 |=> ctrl2 == $past(wb_dat_i[15:0]))
      else $error("control register 2 write lost");
   a_ctrl_hold: assert property (!(wb_cyc_i && wb_we_i) |=>
      $stable(ctrl1) && $stable(ctrl2))
      else $error("control register changed without a write");
   a_area3_select: assert property (plain && ctrl1[11:10] ==
      `PDM_CODE_ALT |=> portd_pin_oe_o[8]
      && portd_pin_o[8] == $past(area3_chip_select_i))
      else $error("area 3 select not on bit 29");
   a_area2_select: assert property (plain && ctrl1[9:8] ==
      `PDM_CODE_ALT |=> portd_pin_oe_o[7]
      && portd_pin_o[7] == $past(area2_chip_select_i))
      else $error("area 2 select not on bit 28");
   a_dma1_ack: assert property (plain && ctrl1[7:6] ==
      `PDM_CODE_ALT |=> portd_pin_oe_o[6]
      && portd_pin_o[6] == $past(dma_ch1_acknowledge_i))
      else $error("channel 1 acknowledge not on bit 27");
   a_dma0_ack: assert property (plain && ctrl1[5:4] ==
      `PDM_CODE_ALT |=> portd_pin_oe_o[5]
      && portd_pin_o[5] == $past(dma_ch0_acknowledge_i))
      else $error("channel 0 acknowledge not on bit 26");
   a_dma1_req: assert property (plain && ctrl1[3:2] ==
      `PDM_CODE_ALT |=> !portd_pin_oe_o[4]
      && dma_ch1_request_o == $past(portd_pin_i[4]))
      else $error("channel 1 request not from bit 25");
   a_dma0_req: assert property (plain && ctrl1[1:0] ==
      `PDM_CODE_ALT |=> !portd_pin_oe_o[3]
      && dma_ch0_request_o == $past(portd_pin_i[3]))
      else $error("channel 0 request not from bit 24");
   a_int7_route: assert property (!rom_less_32_i && ctrl2[15:14] ==
      `PDM_CODE_ALT |=> ext_interrupt_7_o == $past(portd_pin_i[2]))
      else $error("interrupt 7 not from bit 23");
   a_int6_route: assert property (!rom_less_32_i && ctrl2[13:12] ==
      `PDM_CODE_ALT |=> ext_interrupt_6_o == $past(portd_pin_i[1]))
      else $error("interrupt 6 not from bit 22");
   a_int5_route: assert property (!rom_less_32_i && ctrl2[11:10] ==
      `PDM_CODE_ALT |=> ext_interrupt_5_o == $past(portd_pin_i[0]))
      else $error("interrupt 5 not from bit 21");
   a_single_chip_gpio: assert property (single_chip_i &&
      !rom_less_32_i |-> &func_gpio[8:3] ##1
      portd_pin_oe_o[8:3] == $past(gpio_oe_i[8:3]))
      else $error("single-chip pin left in bus or alternate use");
   a_romless_data: assert property (rom_less_32_i |=>
      portd_pin_oe_o == $past(data_oe_i)
      && portd_pin_o == $past(data_out_i))
      else $error("pins not on data lines without ROM");
   a_reserved_gpio: assert property (!rom_less_32_i && ctrl1[11:10] ==
      `PDM_CODE_RSVD |=> portd_pin_o[8] == $past(gpio_out_i[8])
      && portd_pin_oe_o[8] == $past(gpio_oe_i[8]))
      else $error("reserved code not treated as I/O");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   c_ctrl_write: cover property (wb_ack_o && wb_we_i);
   c_area3_used: cover property (plain && func[8] == FUNC_ALT);
   c_single_irq: cover property (single_chip_i && func[2] == FUNC_ALT);
   c_romless: cover property (rom_less_32_i ##1 rom_less_32_i);
endmodule

// *** verification/pdmux_pad_model.sv ***
// Pad model for the upper port D pins, standing where the board would be.
// Assumes the testbench gives the level and the enable of outside drivers.
module pdmux_pad_model (
   // Device side
   input wire logic [8:0] pin_o,
   input wire logic [8:0] pin_oe,
   // Outside drivers
   input wire logic [8:0] ext_lvl,
   input wire logic [8:0] ext_drv,
   // Levels seen by the device
   output logic [8:0] pin_i
);
   // ----------------------------------------------------------------
   // Pad resolution
   // ----------------------------------------------------------------
   // An undriven pad shows the inverse of the last drive, so a pin that is
   // read while nobody drives it never looks like a settled value.
   always_comb begin
      for (int k = 0; k < 9; k++) begin
         if (pin_oe[k]) begin
            pin_i[k] = pin_o[k];
         end else if (ext_drv[k]) begin
            pin_i[k] = ext_lvl[k];
         end else begin
            pin_i[k] = ~pin_o[k];
         end
      end
   end
endmodule

// *** verification/port_d_upper_pin_function_mux_tb_top.sv ***
// Self-checking testbench for the upper port D pin function multiplexer.
// Assumes the design package and header are compiled first.
`include "pdmux_params.svh"
module port_d_upper_pin_function_mux_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic single_chip_i, rom_less_32_i, a3_sel, a2_sel, dk1, dk0;
   logic rq1, rq0, int7, int6, int5;
   logic [8:0] gpio_out_i, gpio_oe_i, data_out_i, data_oe_i, data_in_o;
   logic [8:0] pin_i, pin_o, pin_oe, ext_lvl, ext_drv, gpio_in;
   int bad_count = 0;
   int n_checks = 0;
   int cyc_count = 0;
   logic [31:0] rdv;

   port_d_upper_pin_function_mux uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .single_chip_i(single_chip_i), .rom_less_32_i(rom_less_32_i),
      .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .gpio_in_o(gpio_in),
      .data_out_i(data_out_i), .data_oe_i(data_oe_i),
      .data_in_o(data_in_o), .area3_chip_select_i(a3_sel),
      .area2_chip_select_i(a2_sel), .dma_ch1_acknowledge_i(dk1),
      .dma_ch0_acknowledge_i(dk0), .dma_ch1_request_o(rq1),
      .dma_ch0_request_o(rq0), .ext_interrupt_7_o(int7),
      .ext_interrupt_6_o(int6), .ext_interrupt_5_o(int5),
      .portd_pin_i(pin_i), .portd_pin_o(pin_o), .portd_pin_oe_o(pin_oe));

   pdmux_pad_model pads (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
      .ext_drv(ext_drv), .pin_i(pin_i));

   // ----------------------------------------------------------------
   // Clock, timeout and verdict
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // The whole run needs well under a thousand cycles; this ceiling stops a hang.
   always @(posedge clk_i) begin
      cyc_count++;
      if (cyc_count == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp,
         input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   task automatic wb_xfer(input logic we, input logic [7:0] adr,
         input logic [15:0] dat, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h3;
      wb_dat_i <= {16'h0000, dat};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      chk("wb_ack_wait", 32'h0000_0002, n);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
      wb_xfer(1'b1, adr, dat, rdv);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp,
         input string name);
      wb_xfer(1'b0, adr, 16'h0000, rdv);
      chk(name, exp, rdv);
   endtask

   // Lets the register update land and the pin stage capture it.
   task automatic settle();
      repeat (2) @(posedge clk_i);
   endtask

   function automatic logic [1:0] exp_fn(int k, logic [1:0] c, logic sc);
      if (c == `PDM_CODE_DATA) return sc ? 2'h0 : 2'h1;
      if (c == `PDM_CODE_ALT) return (sc && k >= 3) ? 2'h0 : 2'h2;
      return 2'h0;
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd_chk(`PDM_OFS_CTRL1, 32'h0, "ctrl1");
      rd_chk(`PDM_OFS_CTRL2, 32'h0, "ctrl2");
      rd_chk(`PDM_OFS_STATUS, 32'h0, "status");
      chk("alt_in", 32'h1F, {27'h0, rq1, rq0, int7, int6, int5});
   endtask

   task automatic t_regs();
      wr(`PDM_OFS_CTRL2, 16'hFFFF);
      rd_chk(`PDM_OFS_CTRL2, 32'h0000_FFFF, "ctrl2_ones");
      wr(`PDM_OFS_CTRL2, 16'h9C36);
      rd_chk(`PDM_OFS_CTRL2, 32'h0000_9C36, "ctrl2_mix");
      wr(8'h0C, 16'hFFFF);
      rd_chk(8'h0C, 32'h0, "unmapped");
      rd_chk(`PDM_OFS_CTRL2, 32'h0000_9C36, "ctrl2_kept");
      wr(`PDM_OFS_CTRL2, 16'h0000);
   endtask

   // Every code on every pin, judged through the function status register.
   task automatic t_codes(input logic sc);
      logic [15:0] v;
      logic [17:0] e;
      @(posedge clk_i);
      single_chip_i <= sc;
      for (int k = 0; k < 9; k++) begin
         for (int c = 0; c < 4; c++) begin
            v = 16'h0000;
            e = 18'h00000;
            if (k >= 3) v[(k-3)*2 +: 2] = c[1:0];
            else v[10+k*2 +: 2] = c[1:0];
            e[k*2 +: 2] = exp_fn(k, c[1:0], sc);
            wr(k >= 3 ? `PDM_OFS_CTRL1 : `PDM_OFS_CTRL2, v);
            rd_chk(`PDM_OFS_STATUS, {14'h0, e}, "status");
         end
      end
      wr(`PDM_OFS_CTRL1, 16'h0000);
      wr(`PDM_OFS_CTRL2, 16'h0000);
      @(posedge clk_i);
      single_chip_i <= 1'b0;
   endtask

   task automatic t_alt();
      wr(`PDM_OFS_CTRL1, 16'h0AAA);
      wr(`PDM_OFS_CTRL2, 16'hA800);
      for (int v = 0; v < 2; v++) begin
         @(posedge clk_i);
         {a3_sel, a2_sel, dk1, dk0} <= v ? 4'hA : 4'h5;
         gpio_oe_i <= 9'h1FF;
         gpio_out_i <= v ? 9'h000 : 9'h1FF;
         ext_drv <= 9'h01F;
         ext_lvl <= v ? 9'h015 : 9'h00A;
         settle();
         chk("alt_out", v ? 32'hA : 32'h5, {28'h0, pin_o[8:5]});
         chk("alt_oe", 32'hF, {28'h0, pin_oe[8:5]});
         chk("alt_in", v ? 32'h15 : 32'h0A,
            {27'h0, rq1, rq0, int7, int6, int5});
      end
      @(posedge clk_i);
      single_chip_i <= 1'b1;
      gpio_out_i <= 9'h155;
      settle();
      chk("sc_gpio", 32'h2A, {26'h0, pin_o[8:3]});
      chk("sc_irq", 32'h1D, {27'h0, rq1, rq0, int7, int6, int5});
      @(posedge clk_i);
      single_chip_i <= 1'b0;
   endtask

   task automatic t_romless();
      @(posedge clk_i);
      rom_less_32_i <= 1'b1;
      gpio_oe_i <= 9'h000;
      data_oe_i <= 9'h1FF;
      data_out_i <= 9'h0A5;
      ext_drv <= 9'h000;
      rd_chk(`PDM_OFS_STATUS, 32'h0001_5555, "rl_status");
      settle();
      chk("rl_pin", 32'h0A5, {23'h0, pin_o});
      chk("rl_oe", 32'h1FF, {23'h0, pin_oe});
      @(posedge clk_i);
      data_oe_i <= 9'h000;
      ext_drv <= 9'h1FF;
      ext_lvl <= 9'h13C;
      // Two stages: the enable flop lets go before the input flop samples.
      settle();
      @(posedge clk_i);
      chk("rl_in", 32'h13C, {23'h0, data_in_o});
      chk("rl_gpio_in", 32'h13C, {23'h0, gpio_in});
      chk("rl_idle", 32'h1F, {27'h0, rq1, rq0, int7, int6, int5});
      @(posedge clk_i);
      rom_less_32_i <= 1'b0;
      rd_chk(`PDM_OFS_CTRL1, 32'h0000_0AAA, "kept1");
      rd_chk(`PDM_OFS_CTRL2, 32'h0000_A800, "kept2");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      {single_chip_i, rom_less_32_i, a3_sel, a2_sel, dk1, dk0} = 6'b001111;
      {gpio_out_i, gpio_oe_i, data_out_i, data_oe_i} = 36'h0;
      {ext_lvl, ext_drv} = 18'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_regs();
      t_codes(1'b0);
      t_codes(1'b1);
      t_alt();
      t_romless();
      complete_run();
   end
endmodule
